// ==== rtl/lctp_timer.sv ====
/*
 * Compatibility-mode 8-bit timer/counter with prescaler and PWM on
 * compare A, reached over a classic Wishbone slave.
 * Assumes the fast peripheral clock arrives as a plain level input and
 * that the fuse code is stable while reset is asserted.
 */
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module lctp_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // straps and core signals
    input wire logic [3:0] clock_source_fuses_i,
    input wire logic fast_peripheral_timebase_i,
    input wire logic global_int_enable_i,
    // pin and requests
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe_o,
    output logic compare_a_irq_o,
    output logic overflow_irq_o,
    output logic compat_mode_o
);

    ////////////////////////////////////////////////////////////////////
    // tick selection

    function automatic logic sel_tick(input logic [3:0] cs,
                                      input logic [9:0] cpu_ch,
                                      input logic [2:0] fast_ch,
                                      input logic fast_edge);
        logic [9:0] cmask;
        logic [2:0] fmask;
        logic [3:0] k;
        cmask = 10'h000;
        fmask = 3'h0;
        k = 4'h0;
        sel_tick = 1'b0;
        if (cs >= lctp_pkg::CS_CPU_FIRST) begin
            k = cs - lctp_pkg::CS_CPU_FIRST;
            cmask = 10'((11'h001 << k) - 11'h001);
            sel_tick = &(cpu_ch | ~cmask);
        end else if (cs >= lctp_pkg::CS_FAST_FIRST) begin
            k = cs - lctp_pkg::CS_FAST_FIRST;
            fmask = 3'((4'h1 << k) - 4'h1);
            sel_tick = fast_edge & (&(fast_ch | ~fmask));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic ack_q;
    logic [31:0] dat_q;
    logic compat_q;
    logic fast_meta_q, fast_sync_q, fast_prev_q;
    logic [9:0] cpu_chain_q;
    logic [2:0] fast_chain_q;
    logic [7:0] ctrl_q, gctrl_q, cmp_buf_q, top_q, mask_q;
    logic [7:0] ctrl_s_q, cmp_buf_s_q, top_s_q;
    logic cnt_wr_q;
    logic [7:0] cnt_wr_data_q;
    logic psr_q, force_q;
    logic [1:0] flag_clr_q;
    logic [7:0] cnt_q, cmp_act_q, cnt_rd_q;
    logic [1:0] flag_q, flag_rd_q;
    logic pin_q, pin_oe_q, cmp_irq_q, ovf_irq_q;

    logic req, wr, fast_edge, tick, pwm, at_top;
    logic ovf_set, cmp_set;
    logic [7:0] cnt_nxt;
    logic [1:0] mode;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign fast_edge = fast_sync_q & ~fast_prev_q;
    // timer runs only in compat mode
    assign pwm = compat_q & ctrl_s_q[lctp_pkg::CTRL_PWM_A_BIT];
    assign mode = ctrl_s_q[lctp_pkg::CTRL_MODE_LSB +: 2];
    assign tick = compat_q & sel_tick(ctrl_s_q[lctp_pkg::CTRL_CS_LSB +: 4],
                                      cpu_chain_q, fast_chain_q, fast_edge);
    assign at_top = pwm & (cnt_q == top_s_q);
    assign cnt_nxt = at_top ? lctp_pkg::BYTE_ZERO : cnt_q + 8'h01;
    // overflow on FF wrap or top wrap
    assign ovf_set = tick & ((cnt_q == lctp_pkg::BYTE_FULL) | at_top);
    assign cmp_set = tick & (cnt_nxt == cmp_act_q);

    ////////////////////////////////////////////////////////////////////
    // fuse capture and fast clock sampling

    // fuse code taken while reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compat_q <= (clock_source_fuses_i == lctp_pkg::COMPAT_FUSE_CODE);
        end
    end

    // fast clock sampled into the core domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_meta_q <= 1'b0;
            fast_sync_q <= 1'b0;
            fast_prev_q <= 1'b0;
        end else begin
            fast_meta_q <= fast_peripheral_timebase_i;
            fast_sync_q <= fast_meta_q;
            fast_prev_q <= fast_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler chains

    // 10-bit cpu chain and 3-bit fast chain
    always_ff @(posedge clk_i) begin
        if (rst_i || psr_q) begin
            cpu_chain_q <= 10'h000;
            fast_chain_q <= 3'h0;
        end else begin
            cpu_chain_q <= cpu_chain_q + 10'h001;
            if (fast_edge) begin
                fast_chain_q <= fast_chain_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave and software registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= lctp_pkg::CTRL_RESET;
            gctrl_q <= lctp_pkg::BYTE_ZERO;
            cmp_buf_q <= lctp_pkg::BYTE_ZERO;
            top_q <= lctp_pkg::TOP_RESET;
            mask_q <= lctp_pkg::BYTE_ZERO;
        end else if (wr) begin
            unique case (wb_adr_i)
                lctp_pkg::OFF_CTRL: ctrl_q <= wb_dat_i[7:0];
                lctp_pkg::OFF_GCTRL: gctrl_q <= wb_dat_i[7:0];
                lctp_pkg::OFF_CMP_A: cmp_buf_q <= wb_dat_i[7:0];
                lctp_pkg::OFF_TOP: top_q <= wb_dat_i[7:0];
                lctp_pkg::OFF_MASK: mask_q <= wb_dat_i[7:0] &
                                              lctp_pkg::FLAG_READ_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_s_q <= lctp_pkg::CTRL_RESET;
            cmp_buf_s_q <= lctp_pkg::BYTE_ZERO;
            top_s_q <= lctp_pkg::TOP_RESET;
            cnt_wr_q <= 1'b0;
            cnt_wr_data_q <= lctp_pkg::BYTE_ZERO;
            psr_q <= 1'b0;
            force_q <= 1'b0;
            flag_clr_q <= 2'h0;
        end else begin
            ctrl_s_q <= ctrl_q;
            cmp_buf_s_q <= cmp_buf_q;
            top_s_q <= top_q;
            cnt_wr_q <= wr & (wb_adr_i == lctp_pkg::OFF_COUNT);
            cnt_wr_data_q <= wb_dat_i[7:0];
            psr_q <= wr & (wb_adr_i == lctp_pkg::OFF_GCTRL) &
                     wb_dat_i[lctp_pkg::GCTRL_PSR_BIT];
            force_q <= wr & (wb_adr_i == lctp_pkg::OFF_GCTRL) &
                       wb_dat_i[lctp_pkg::GCTRL_FORCE_A_BIT];
            flag_clr_q <= {2{wr & (wb_adr_i == lctp_pkg::OFF_FLAG)}} &
                          {wb_dat_i[lctp_pkg::FLAG_CMP_A_BIT],
                           wb_dat_i[lctp_pkg::FLAG_OVF_BIT]};
        end
    end

    // read data; every register answers in one cycle, count and flags from one-cycle-old copies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req) begin
            dat_q <= 32'h0000_0000;
            unique case (wb_adr_i)
                lctp_pkg::OFF_CTRL: dat_q[7:0] <= ctrl_q;
                lctp_pkg::OFF_GCTRL: dat_q[7:0] <= gctrl_q &
                                                   lctp_pkg::GCTRL_READ_MASK;
                lctp_pkg::OFF_CMP_A: dat_q[7:0] <= cmp_buf_q;
                lctp_pkg::OFF_TOP: dat_q[7:0] <= top_q;
                lctp_pkg::OFF_COUNT: dat_q[7:0] <= cnt_rd_q;
                lctp_pkg::OFF_FLAG: begin
                    dat_q[lctp_pkg::FLAG_CMP_A_BIT] <= flag_rd_q[1];
                    dat_q[lctp_pkg::FLAG_OVF_BIT] <= flag_rd_q[0];
                end
                lctp_pkg::OFF_MASK: dat_q[7:0] <= mask_q;
                lctp_pkg::OFF_STATUS: dat_q[0] <= compat_q;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter and compare

    // no tick while stopped, count held
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= lctp_pkg::BYTE_ZERO;
        end else if (cnt_wr_q) begin
            cnt_q <= cnt_wr_data_q;
        end else if (tick) begin
            // clear on the tick after top
            cnt_q <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_act_q <= lctp_pkg::BYTE_ZERO;
        end else if (!pwm || (tick && at_top)) begin
            cmp_act_q <= cmp_buf_s_q;
        end
    end

    // output sync stage for count readback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_rd_q <= lctp_pkg::BYTE_ZERO;
        end else begin
            cnt_rd_q <= cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flags and requests

    // a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 2'h0;
            flag_rd_q <= 2'h0;
        end else begin
            flag_q <= (flag_q & ~flag_clr_q) | {cmp_set, ovf_set};
            flag_rd_q <= flag_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
        end else begin
            cmp_irq_q <= flag_q[1] & mask_q[lctp_pkg::FLAG_CMP_A_BIT] &
                         global_int_enable_i;
            ovf_irq_q <= flag_q[0] & mask_q[lctp_pkg::FLAG_OVF_BIT] &
                         global_int_enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare output pin

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else if (pwm) begin
            // pin connected for modes 10 and 11, and for 01 when compare A is zero or equals top
            pin_oe_q <= mode[1] | ((mode == lctp_pkg::MODE_TOGGLE) &
                        ((cmp_act_q == lctp_pkg::BYTE_ZERO) |
                         (cmp_act_q == top_s_q)));
            if (cmp_act_q == lctp_pkg::BYTE_ZERO) begin
                pin_q <= (mode == lctp_pkg::MODE_SET);
            end else if (cmp_act_q == top_s_q) begin
                pin_q <= (mode != lctp_pkg::MODE_SET);
            end else if (cmp_set) begin
                // match clears in 10, sets in 11
                pin_q <= (mode == lctp_pkg::MODE_SET);
            end else if (tick && cnt_nxt == lctp_pkg::BYTE_ZERO) begin
                // period ends at the wrap to zero
                pin_q <= (mode == lctp_pkg::MODE_CLEAR);
            end
        end else begin
            pin_oe_q <= compat_q & (mode != lctp_pkg::MODE_OFF);
            if (cmp_set || force_q) begin
                unique case (mode)
                    lctp_pkg::MODE_OFF: ;
                    lctp_pkg::MODE_TOGGLE: pin_q <= ~pin_q;
                    lctp_pkg::MODE_CLEAR: pin_q <= 1'b0;
                    lctp_pkg::MODE_SET: pin_q <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign compare_output_pin_o = pin_q;
    assign compare_output_pin_oe_o = pin_oe_q;
    assign compare_a_irq_o = cmp_irq_q;
    assign overflow_irq_o = ovf_irq_q;
    assign compat_mode_o = compat_q;

endmodule // lctp_timer

`default_nettype wire

// ==== rtl/lctp_pkg.sv ====
/*
 * Constants for the compatibility timer/PWM: register offsets, field
 * positions, reset values and clock-select codes.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package lctp_pkg;
    // clock rates
    localparam int CPU_CLK_HZ = 100_000_000;
    localparam int FAST_CLK_HZ = 25_600_000;

    // fuse code that selects the compatibility mode
    localparam logic [3:0] COMPAT_FUSE_CODE = 4'h3;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_GCTRL = 8'h04;
    localparam logic [7:0] OFF_CMP_A = 8'h08;
    localparam logic [7:0] OFF_TOP = 8'h0C;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    localparam logic [7:0] OFF_FLAG = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // timer_control_reg fields
    localparam int CTRL_PWM_A_BIT = 6;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_CS_LSB = 0;

    // general_timer_control_reg fields
    localparam int GCTRL_FORCE_A_BIT = 2;
    localparam int GCTRL_PSR_BIT = 1;
    localparam logic [7:0] GCTRL_READ_MASK = 8'hF9;

    // flag and mask fields
    localparam int FLAG_CMP_A_BIT = 6;
    localparam int FLAG_OVF_BIT = 2;
    localparam logic [7:0] FLAG_READ_MASK = 8'h44;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] TOP_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_FULL = 8'hFF;

    // clock_select_field codes
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [3:0] CS_FAST_FIRST = 4'h1;
    localparam logic [3:0] CS_FAST_LAST = 4'h4;
    localparam logic [3:0] CS_CPU_FIRST = 4'h5;

    // output_mode_field codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;
    localparam logic [1:0] MODE_SET = 2'h3;
endpackage

// ==== testbench/lctp_timer_chk.sv ====
/* checker for lctp_timer: bus answers, mode strap, pin enable, requests
   assumes one core clock and a synchronous active-high reset */
`timescale 1ns/1ps
`default_nettype none
module lctp_timer_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // straps and outputs
    input wire logic [3:0] clock_source_fuses_i,
    input wire logic global_int_enable_i,
    input wire logic compare_output_pin_oe_o,
    input wire logic compare_a_irq_o,
    input wire logic overflow_irq_o,
    input wire logic compat_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack longer than one cycle");
    property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == '0; endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("read data above the low byte");
    property p_status;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        wb_adr_i == lctp_pkg::OFF_STATUS
        |=> wb_dat_o == {31'h0000_0000, compat_mode_o};
    endproperty
    a_status: assert property (p_status)
        else $error("status read differs from mode");
    property p_compat;
        $fell(rst_i) |->
        compat_mode_o == (clock_source_fuses_i == lctp_pkg::COMPAT_FUSE_CODE);
    endproperty
    a_compat: assert property (p_compat)
        else $error("mode does not follow fuses");
    property p_oe_idle; !compat_mode_o |-> !compare_output_pin_oe_o; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("pin driven outside compatibility mode");
    property p_ovf_irq; overflow_irq_o |-> $past(global_int_enable_i); endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow request without global enable");
    property p_cmp_irq; compare_a_irq_o |-> $past(global_int_enable_i); endproperty
    a_cmp_irq: assert property (p_cmp_irq)
        else $error("compare request without global enable");
endmodule // lctp_timer_chk
bind lctp_timer lctp_timer_chk u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .clock_source_fuses_i(clock_source_fuses_i),
    .global_int_enable_i(global_int_enable_i),
    .compare_output_pin_oe_o(compare_output_pin_oe_o),
    .compare_a_irq_o(compare_a_irq_o), .overflow_irq_o(overflow_irq_o),
    .compat_mode_o(compat_mode_o));
`default_nettype wire

// ==== testbench/lctp_timer_test.sv ====
/* self-checking bench for lctp_timer: wishbone master, fast clock source
   assumes the package and design are compiled before this file */
`timescale 1ns/1ps
`default_nettype none
module lctp_timer_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] fuses = 4'h3;
    logic fast = 1'b0;
    logic gie = 1'b1;
    logic ack;
    logic [31:0] rdat;
    logic pin;
    logic pin_oe;
    logic irq_a;
    logic irq_ovf;
    logic compat;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    int mismatches = 0;
    int checks_done = 0;
    int ph = 0;
    logic [7:0] ra[7] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [7:0] rv[7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] wa[4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    lctp_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .clock_source_fuses_i(fuses), .fast_peripheral_timebase_i(fast),
        .global_int_enable_i(gie), .compare_output_pin_o(pin),
        .compare_output_pin_oe_o(pin_oe), .compare_a_irq_o(irq_a),
        .overflow_irq_o(irq_ovf), .compat_mode_o(compat));
    initial forever #5 clk_i = ~clk_i;
    // fast timebase averages 25.6 MHz off the core clock
    always @(posedge clk_i) begin
        if (ph >= 488)
            fast <= ~fast;
        ph <= (ph + 512) % 1000;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        end_sim();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: read %h not %h", $time, got, exp);
        end
    endtask
    task automatic check_lvl(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: level %b not %b", $time, got, exp);
        end
    endtask
    // results come off the queue in request order
    always @(posedge clk_i) begin
        if (ack === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[64])
                check(rdat & note[31:0], note[63:32]);
        end
    end
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d, input logic [3:0] s, input logic c,
        input logic [7:0] e, input logic [7:0] m);
        int n;
        n = 0;
        @(posedge clk_i);
        exp_q.push_back({c, 24'h00_0000, e, 24'hFF_FFFF, m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            hang();
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rise();
        int n;
        n = 0;
        while ((pin !== 1'b0 || n == 0) && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        while (pin !== 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 9000)
            hang();
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #900_000;
        hang();
    end
    initial begin
        logic [7:0] v;
        realtime t0;
        real d;
        void'($urandom(32'h90d1bd28));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++)
            bus(1'b0, ra[i], 8'h00, 4'h1, 1'b1, rv[i], 8'hFF);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? ((8'($urandom()) & 8'hB0) | 8'h40) : 8'($urandom());
            bus(1'b1, wa[i], v, 4'h1, 1'b0, 8'h00, 8'h00);
            if (i == 1)
                v = v & lctp_pkg::GCTRL_READ_MASK;
            bus(1'b0, wa[i], 8'h00, 4'h1, 1'b1, v, 8'hFF);
        end
        // low byte lane off: write ignored
        bus(1'b1, 8'h00, 8'h40, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'h00, 8'h0F, 4'hE, 1'b0, 8'h00, 8'h00);
        bus(1'b0, 8'h00, 8'h00, 4'h1, 1'b1, 8'h40, 8'hFF);
        bus(1'b1, 8'h10, 8'h37, 4'h1, 1'b0, 8'h00, 8'h00);
        repeat (20) @(posedge clk_i);
        bus(1'b0, 8'h10, 8'h00, 4'h1, 1'b1, 8'h37, 8'hFF);
        bus(1'b1, 8'h18, 8'h44, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'h08, 8'h03, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'h10, 8'hFE, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'h00, 8'h05, 4'h1, 1'b0, 8'h00, 8'h00);
        repeat (12) @(posedge clk_i);
        bus(1'b1, 8'h00, 8'h00, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b0, 8'h14, 8'h00, 4'h1, 1'b1, 8'h44, 8'hFF);
        repeat (2) @(negedge clk_i);
        check_lvl(irq_ovf, 1'b1);
        check_lvl(irq_a, 1'b1);
        @(posedge clk_i);
        gie <= 1'b0;
        repeat (3) @(negedge clk_i);
        check_lvl(irq_ovf | irq_a, 1'b0);
        @(posedge clk_i);
        gie <= 1'b1;
        bus(1'b1, 8'h14, 8'h44, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b0, 8'h14, 8'h00, 4'h1, 1'b1, 8'h00, 8'hFF);
        // pwm, top 3, clear on match 1: one pin rise per period
        bus(1'b1, 8'h0C, 8'h03, 4'h1, 1'b0, 8'h00, 8'h00);
        bus(1'b1, 8'h08, 8'h01, 4'h1, 1'b0, 8'h00, 8'h00);
        for (int cs = 1; cs < 16; cs++) begin
            bus(1'b1, 8'h00, {4'h6, cs[3:0]}, 4'h1, 1'b0, 8'h00, 8'h00);
            rise();
            t0 = $realtime;
            rise();
            d = (cs < 5) ? 156.25 * (1 << (cs - 1)) : 40.0 * (1 << (cs - 5));
            d = $realtime - t0 - d;
            check_lvl(d < 10.5 && d > -10.5, 1'b1);
        end
        for (int m = 1; m < 4; m++)
            for (int c = 0; c < 2; c++) begin
                v = c ? 8'h03 : 8'h00;
                bus(1'b1, 8'h08, v, 4'h1, 1'b0, 8'h00, 8'h00);
                bus(1'b1, 8'h00, {2'b01, m[1:0], 4'h5}, 4'h1, 1'b0, 8'h00, 8'h00);
                repeat (12) @(negedge clk_i);
                repeat (8) begin
                    @(negedge clk_i);
                    check_lvl(pin, c[0] ^ (m == 3));
                    check_lvl(pin_oe, 1'b1);
                end
            end
        // normal mode: forced compare action in set, clear and toggle output modes
        for (int k = 3; k > 0; k--) begin
            bus(1'b1, 8'h00, {2'b00, k[1:0], 4'h0}, 4'h1, 1'b0, 8'h00,
                8'h00);
            bus(1'b1, 8'h04, 8'h04, 4'h1, 1'b0, 8'h00, 8'h00);
            repeat (3) @(negedge clk_i);
            check_lvl(pin, k[0]);
            check_lvl(pin_oe, 1'b1);
        end
        @(posedge clk_i);
        fuses <= 4'h0;
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h1C, 8'h00, 4'h1, 1'b1, 8'h00, 8'hFF);
        bus(1'b1, 8'h00, 8'h65, 4'h1, 1'b0, 8'h00, 8'h00);
        repeat (20) @(negedge clk_i);
        check_lvl(pin_oe, 1'b0);
        check_lvl(compat, 1'b0);
        end_sim();
    end
endmodule // lctp_timer_test
`default_nettype wire
